// ==== cfg_dev.sv ====
// Power-up configuration loader: mode and address straps, EEPROM master, then bus slave.
`timescale 1ns/1ps
`include "cfg_defs.svh"
module cfg_dev #(
	parameter int REG_CNT  = 16,
	parameter int SCL_HALF = `CFG_SCL_HALF_CYC
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          ce,
	cfg_link_if.dev            link,
	input  wire logic [3:0]    lock,
	input  wire logic [7:0]    rd_idx,
	output logic      [7:0]    rd_data,
	output logic      [6:0]    bus_addr,
	output logic               slave_mode,
	output logic               load_done,
	output cfg_pkg::cfg_state_e state
);
	import cfg_pkg::*;
	localparam int IW = $clog2(REG_CNT);
	localparam logic [7:0] EE_RD = {`CFG_EE_ADDR, `CFG_RW_READ};

	cfg_state_e  state_reg;
	cfg_bus_e    bus_reg;
	logic [7:0]  s1_reg;
	logic [7:0]  s2_reg;
	logic        scl_d_reg;
	logic        sda_d_reg;
	logic [2:0]  wait_reg;
	logic [6:0]  addr_reg;
	logic        slave_reg;
	logic        done_oe_reg;
	logic        strap_oe_reg;
	logic [3:0]  lock_reg;
	logic [15:0] div_reg;
	logic        ph_reg;
	logic [3:0]  bit_reg;
	logic [7:0]  shift_reg;
	logic [IW-1:0] byte_reg;
	logic [7:0]  ptr_reg;
	logic        rw_reg;
	logic        scl_oe_reg;
	logic        sda_oe_reg;
	logic        fin_reg;
	logic [7:0]  rd_reg;
	logic [7:0]  regs [REG_CNT];
	logic        scl_s;
	logic        sda_s;
	logic        mode_s;
	logic        lreq_s;
	logic [3:0]  strap_s;
	logic        tick;
	logic        rise;
	logic        fall;
	logic        s_start;
	logic        s_stop;
	logic [IW-1:0] pi;

	assign scl_s   = s2_reg[7];
	assign sda_s   = s2_reg[6];
	assign mode_s  = s2_reg[5];
	assign lreq_s  = s2_reg[4];
	assign strap_s = s2_reg[3:0];
	assign tick    = (div_reg == 16'(SCL_HALF - 1));
	assign rise    = scl_s & ~scl_d_reg;
	assign fall    = ~scl_s & scl_d_reg;
	assign s_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign s_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign pi      = ptr_reg[IW-1:0];

	assign link.sbclk_dev_o  = 1'b0;
	assign link.sbclk_dev_oe = scl_oe_reg;
	assign link.sda_dev_o    = 1'b0;
	assign link.sda_dev_oe   = sda_oe_reg;
	assign link.done_dev_o   = 1'b0;
	assign link.done_dev_oe  = done_oe_reg;
	assign link.lock_dev_o   = lock_reg;
	assign link.lock_dev_oe  = strap_oe_reg;
	assign rd_data    = rd_reg;
	assign bus_addr   = addr_reg;
	assign slave_mode = slave_reg;
	assign load_done  = done_oe_reg;
	assign state      = state_reg;

	// All pins come from outside this clock and pass two flops first.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_reg    <= `CFG_SYNC_RST;
			s2_reg    <= `CFG_SYNC_RST;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else if (ce) begin
			s1_reg    <= {link.serial_bus_clock_pin, link.sda, link.config_mode_select_pin,
				link.lreq_n, link.strap};
			s2_reg    <= s1_reg;
			scl_d_reg <= s2_reg[7];
			sda_d_reg <= s2_reg[6];
		end
	end

	// Power-up sequencing; the wait lets the synchronisers fill before the straps are taken.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg    <= CFG_ST_STRAP;
			wait_reg     <= 3'h0;
			addr_reg     <= 7'h00;
			slave_reg    <= 1'b0;
			done_oe_reg  <= 1'b0;
			strap_oe_reg <= 1'b0;
		end else if (ce) begin
			unique case (state_reg)
				CFG_ST_STRAP: begin
					if (wait_reg == `CFG_STRAP_WAIT) begin
						slave_reg <= mode_s;
						if (mode_s && lreq_s) begin
							addr_reg <= `CFG_FIXED_ADDR;
						end else begin
							addr_reg <= `CFG_ADDR_BASE + {3'h0, strap_s};
						end
						strap_oe_reg <= 1'b1;
						state_reg    <= mode_s ? CFG_ST_SLAVE : CFG_ST_WAIT;
					end else begin
						wait_reg <= wait_reg + 3'h1;
					end
				end
				CFG_ST_WAIT: begin
					if (!lreq_s) begin
						state_reg <= CFG_ST_LOAD;
					end
				end
				CFG_ST_LOAD: begin
					if (fin_reg) begin
						done_oe_reg <= 1'b1;
						state_reg   <= CFG_ST_SLAVE;
					end
				end
				CFG_ST_SLAVE: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lock_reg <= 4'h0;
			rd_reg   <= 8'h00;
		end else if (ce) begin
			lock_reg <= lock;
			rd_reg   <= regs[rd_idx[IW-1:0]];
		end
	end

	// The bus clock is made here only while loading; it idles high otherwise.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_reg <= 16'h0000;
		end else if (ce) begin
			if (state_reg != CFG_ST_LOAD || tick) begin
				div_reg <= 16'h0000;
			end else begin
				div_reg <= div_reg + 16'h0001;
			end
		end
	end

	// Bus engine: master while loading, slave afterwards. Clock stretching is not honoured.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bus_reg    <= BUS_IDLE;
			ph_reg     <= 1'b0;
			bit_reg    <= 4'h0;
			shift_reg  <= 8'h00;
			byte_reg   <= '0;
			ptr_reg    <= 8'h00;
			rw_reg     <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			fin_reg    <= 1'b0;
			for (int i = 0; i < REG_CNT; i++) begin
				regs[i] <= 8'h00;
			end
		end else if (ce) begin
			if (state_reg == CFG_ST_LOAD) begin
				if (bus_reg == BUS_IDLE && !fin_reg) begin
					bus_reg <= BUS_MSTART;
					ph_reg  <= 1'b0;
				end else if (tick && bus_reg == BUS_MSTART) begin
					if (!ph_reg) begin
						sda_oe_reg <= 1'b1;
						ph_reg     <= 1'b1;
					end else begin
						scl_oe_reg <= 1'b1;
						ph_reg     <= 1'b0;
						shift_reg  <= EE_RD;
						sda_oe_reg <= ~EE_RD[7];
						bit_reg    <= 4'h0;
						bus_reg    <= BUS_MTX;
					end
				end else if (tick && !ph_reg) begin
					scl_oe_reg <= 1'b0;
					ph_reg     <= 1'b1;
				end else if (tick) begin
					ph_reg <= 1'b0;
					if (bus_reg == BUS_MSTOP) begin
						sda_oe_reg <= 1'b0;
						bus_reg    <= BUS_IDLE;
						fin_reg    <= 1'b1;
					end else if (bus_reg == BUS_MTX) begin
						scl_oe_reg <= 1'b1;
						if (bit_reg == 4'h8) begin
							bit_reg    <= 4'h0;
							byte_reg   <= '0;
							sda_oe_reg <= sda_s;
							bus_reg    <= sda_s ? BUS_MSTOP : BUS_MRX;
						end else begin
							bit_reg    <= bit_reg + 4'h1;
							shift_reg  <= {shift_reg[6:0], 1'b0};
							sda_oe_reg <= (bit_reg == 4'h7) ? 1'b0 : ~shift_reg[6];
						end
					end else begin
						scl_oe_reg <= 1'b1;
						if (bit_reg == 4'h8) begin
							bit_reg    <= 4'h0;
							byte_reg   <= byte_reg + IW'(1);
							sda_oe_reg <= (byte_reg == IW'(REG_CNT - 1));
							if (byte_reg == IW'(REG_CNT - 1)) begin
								bus_reg <= BUS_MSTOP;
							end
						end else begin
							shift_reg <= {shift_reg[6:0], sda_s};
							bit_reg   <= bit_reg + 4'h1;
							if (bit_reg == 4'h7) begin
								regs[byte_reg] <= {shift_reg[6:0], sda_s};
								sda_oe_reg     <= (byte_reg != IW'(REG_CNT - 1));
							end
						end
					end
				end
			end else if (state_reg == CFG_ST_SLAVE) begin
				scl_oe_reg <= 1'b0;
				if (s_stop) begin
					bus_reg    <= BUS_IDLE;
					sda_oe_reg <= 1'b0;
				end else if (s_start) begin
					bus_reg    <= BUS_SADDR;
					bit_reg    <= 4'h0;
					sda_oe_reg <= 1'b0;
				end else if (bus_reg != BUS_IDLE && rise) begin
					if (bit_reg < 4'h8) begin
						bit_reg <= bit_reg + 4'h1;
						if (bus_reg != BUS_SRD) begin
							shift_reg <= {shift_reg[6:0], sda_s};
						end
					end else if (bit_reg == 4'h8 && bus_reg == BUS_SRD) begin
						bit_reg <= 4'h9;
						if (sda_s) begin
							bus_reg <= BUS_IDLE;
						end
					end
				end else if (bus_reg != BUS_IDLE && fall) begin
					if (bit_reg == 4'h8 && bus_reg != BUS_SRD) begin
						if (bus_reg == BUS_SADDR && shift_reg[7:1] != addr_reg) begin
							bus_reg <= BUS_IDLE;
						end else begin
							sda_oe_reg <= 1'b1;
							bit_reg    <= 4'h9;
							if (bus_reg == BUS_SADDR) begin
								rw_reg <= shift_reg[0];
							end
							if (bus_reg == BUS_SPTR) begin
								ptr_reg <= shift_reg;
							end
							if (bus_reg == BUS_SWR) begin
								regs[pi] <= shift_reg;
								ptr_reg  <= ptr_reg + 8'h01;
							end
						end
					end else if (bit_reg == 4'h9) begin
						bit_reg <= 4'h0;
						if (bus_reg == BUS_SRD || (bus_reg == BUS_SADDR && rw_reg)) begin
							bus_reg    <= BUS_SRD;
							sda_oe_reg <= ~regs[pi][7];
							shift_reg  <= {regs[pi][6:0], 1'b0};
							ptr_reg    <= ptr_reg + 8'h01;
						end else begin
							sda_oe_reg <= 1'b0;
							bus_reg    <= (bus_reg == BUS_SADDR) ? BUS_SPTR : BUS_SWR;
						end
					end else if (bus_reg == BUS_SRD) begin
						sda_oe_reg <= (bit_reg == 4'h8) ? 1'b0 : ~shift_reg[7];
						shift_reg  <= {shift_reg[6:0], 1'b0};
					end
				end
			end
		end
	end
endmodule : cfg_dev

// ==== cfg_defs.svh ====
// Shared constants of the configuration loader and its partner.
`ifndef CFG_DEFS_SVH
`define CFG_DEFS_SVH
`define CFG_ADDR_BASE     7'h18
`define CFG_FIXED_ADDR    7'h18
`define CFG_EE_ADDR       7'h50
`define CFG_RW_WRITE      1'b0
`define CFG_RW_READ       1'b1
`define CFG_EE_SEED       8'ha5
`define CFG_SYNC_RST      8'hd0
`define CFG_STRAP_WAIT    3'h7
`define CFG_CLK_NS        25
`define CFG_SCL_HALF_NS   5000
`define CFG_SCL_HALF_CYC  ((`CFG_SCL_HALF_NS + `CFG_CLK_NS - 1) / `CFG_CLK_NS)
`endif

// ==== cfg_pkg.sv ====
// Types of the configuration loader and its partner.
package cfg_pkg;
	typedef enum logic [3:0] {
		CFG_ST_STRAP = 4'h1,
		CFG_ST_WAIT  = 4'h2,
		CFG_ST_LOAD  = 4'h4,
		CFG_ST_SLAVE = 4'h8
	} cfg_state_e;
	typedef enum logic [8:0] {
		BUS_IDLE   = 9'h001,
		BUS_MSTART = 9'h002,
		BUS_MTX    = 9'h004,
		BUS_MRX    = 9'h008,
		BUS_MSTOP  = 9'h010,
		BUS_SADDR  = 9'h020,
		BUS_SPTR   = 9'h040,
		BUS_SWR    = 9'h080,
		BUS_SRD    = 9'h100
	} cfg_bus_e;
endpackage : cfg_pkg

// ==== cfg_link_if.sv ====
// Board wiring between the loader and its host: open-drain bus, straps and chain pins.
`timescale 1ns/1ps
interface cfg_link_if;
	logic       sbclk_dev_o;
	logic       sbclk_dev_oe;
	logic       sbclk_host_o;
	logic       sbclk_host_oe;
	logic       sda_dev_o;
	logic       sda_dev_oe;
	logic       sda_host_o;
	logic       sda_host_oe;
	logic       mode_host_o;
	logic       mode_host_oe;
	logic       lreq_host_o;
	logic       lreq_host_oe;
	logic       done_dev_o;
	logic       done_dev_oe;
	logic [3:0] strap_host_o;
	logic       strap_host_oe;
	logic [3:0] lock_dev_o;
	logic       lock_dev_oe;
	logic       serial_bus_clock_pin;
	logic       sda;
	logic       config_mode_select_pin;
	logic       lreq_n;
	logic       done_n;
	logic [3:0] strap;
	// Pull-ups on the bus and chain lines; a floating mode pin reads low.
	assign serial_bus_clock_pin = (sbclk_dev_oe ? sbclk_dev_o : 1'b1)
		& (sbclk_host_oe ? sbclk_host_o : 1'b1);
	assign sda = (sda_dev_oe ? sda_dev_o : 1'b1) & (sda_host_oe ? sda_host_o : 1'b1);
	assign config_mode_select_pin = mode_host_oe ? mode_host_o : 1'b0;
	assign lreq_n = lreq_host_oe ? lreq_host_o : 1'b1;
	assign done_n = done_dev_oe ? done_dev_o : 1'b1;
	// Strap resistors are weak, so the lock drivers win once enabled.
	assign strap = lock_dev_oe ? lock_dev_o : (strap_host_oe ? strap_host_o : 4'h0);
	modport dev (
		input  serial_bus_clock_pin, sda, config_mode_select_pin, lreq_n, strap,
		output sbclk_dev_o, sbclk_dev_oe, sda_dev_o, sda_dev_oe,
		output done_dev_o, done_dev_oe, lock_dev_o, lock_dev_oe
	);
	modport host (
		input  serial_bus_clock_pin, sda, done_n,
		output sbclk_host_o, sbclk_host_oe, sda_host_o, sda_host_oe,
		output mode_host_o, mode_host_oe, lreq_host_o, lreq_host_oe,
		output strap_host_o, strap_host_oe
	);
endinterface : cfg_link_if

// ==== cfg_host.sv ====
// Board side: mode and strap pins, chain start, EEPROM responder and bus controller.
`timescale 1ns/1ps
`include "cfg_defs.svh"
module cfg_host #(
	parameter int SCL_HALF = `CFG_SCL_HALF_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	cfg_link_if.host        link,
	input  wire logic       mode_high,
	input  wire logic [3:0] strap_val,
	input  wire logic       req_low,
	input  wire logic       cmd_valid,
	input  wire logic       cmd_rd,
	input  wire logic [6:0] cmd_dev,
	input  wire logic [7:0] cmd_reg,
	input  wire logic [7:0] cmd_wdata,
	output logic            cmd_ready,
	output logic            rsp_valid,
	output logic [7:0]      rsp_data,
	output logic            rsp_nack,
	output logic            chain_done
);
	import cfg_pkg::*;

	cfg_bus_e    mb_reg;
	logic [2:0]  s1_reg;
	logic [2:0]  s2_reg;
	logic        scl_d_reg;
	logic        sda_d_reg;
	logic        mode_reg;
	logic        lreq_reg;
	logic [3:0]  strap_reg;
	logic        strap_oe_reg;
	logic [15:0] div_reg;
	logic        ph_reg;
	logic [3:0]  bit_reg;
	logic [7:0]  shift_reg;
	logic [7:0]  bytes [3];
	logic [1:0]  idx_reg;
	logic [1:0]  last_reg;
	logic        rd_reg;
	logic        second_reg;
	logic [6:0]  dev_reg;
	logic        scl_oe_reg;
	logic        m_oe_reg;
	logic        ready_reg;
	logic        valid_reg;
	logic [7:0]  data_reg;
	logic        nack_reg;
	logic        ee_on_reg;
	logic        ee_rd_reg;
	logic [3:0]  ebit_reg;
	logic [7:0]  eshift_reg;
	logic [7:0]  eptr_reg;
	logic        ee_oe_reg;
	logic        sda_oe_reg;
	logic        done_reg;
	logic        scl_s;
	logic        sda_s;
	logic        tick;
	logic        rise;
	logic        fall;
	logic [1:0]  nxt;
	logic [7:0]  ee_byte;

	assign scl_s   = s2_reg[2];
	assign sda_s   = s2_reg[1];
	assign tick    = (div_reg == 16'(SCL_HALF - 1));
	assign rise    = scl_s & ~scl_d_reg;
	assign fall    = ~scl_s & scl_d_reg;
	assign nxt     = idx_reg + 2'h1;
	// EEPROM content is a fixed pattern, so no storage is needed.
	assign ee_byte = `CFG_EE_SEED ^ eptr_reg;

	assign link.sbclk_host_o  = 1'b0;
	assign link.sbclk_host_oe = scl_oe_reg;
	assign link.sda_host_o    = 1'b0;
	assign link.sda_host_oe   = sda_oe_reg;
	assign link.mode_host_o   = 1'b1;
	assign link.mode_host_oe  = mode_reg;
	assign link.lreq_host_o   = 1'b0;
	assign link.lreq_host_oe  = lreq_reg;
	assign link.strap_host_o  = strap_reg;
	assign link.strap_host_oe = strap_oe_reg;
	assign cmd_ready  = ready_reg;
	assign rsp_valid  = valid_reg;
	assign rsp_data   = data_reg;
	assign rsp_nack   = nack_reg;
	assign chain_done = done_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_reg    <= 3'h7;
			s2_reg    <= 3'h7;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			done_reg  <= 1'b0;
		end else if (ce) begin
			s1_reg    <= {link.serial_bus_clock_pin, link.sda, link.done_n};
			s2_reg    <= s1_reg;
			scl_d_reg <= s2_reg[2];
			sda_d_reg <= s2_reg[1];
			done_reg  <= ~s2_reg[0];
		end
	end

	// Board pins; the request is held low from the cycle after reset when asked; it starts a load in master mode and picks the strapped address in slave mode.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_reg     <= 1'b0;
			lreq_reg     <= 1'b0;
			strap_reg    <= 4'h0;
			strap_oe_reg <= 1'b0;
			sda_oe_reg   <= 1'b0;
		end else if (ce) begin
			mode_reg     <= mode_high;
			lreq_reg     <= req_low;
			strap_reg    <= strap_val;
			strap_oe_reg <= 1'b1;
			sda_oe_reg   <= m_oe_reg | ee_oe_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_reg <= 16'h0000;
		end else if (ce) begin
			if (mb_reg == BUS_IDLE || tick) begin
				div_reg <= 16'h0000;
			end else begin
				div_reg <= div_reg + 16'h0001;
			end
		end
	end

	// EEPROM: answers a read at its address, streaming bytes until the master refuses one.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ee_on_reg  <= 1'b0;
			ee_rd_reg  <= 1'b0;
			ebit_reg   <= 4'h0;
			eshift_reg <= 8'h00;
			eptr_reg   <= 8'h00;
			ee_oe_reg  <= 1'b0;
		end else if (ce) begin
			if (scl_s && scl_d_reg && sda_s != sda_d_reg) begin
				ee_on_reg <= ~sda_s;
				ee_rd_reg <= 1'b0;
				ebit_reg  <= 4'h0;
				ee_oe_reg <= 1'b0;
			end else if (ee_on_reg && rise) begin
				if (ebit_reg < 4'h8) begin
					ebit_reg   <= ebit_reg + 4'h1;
					eshift_reg <= ee_rd_reg ? eshift_reg : {eshift_reg[6:0], sda_s};
				end else if (ebit_reg == 4'h8 && ee_rd_reg) begin
					ebit_reg  <= 4'h9;
					ee_on_reg <= ~sda_s;
				end
			end else if (ee_on_reg && fall) begin
				if (ebit_reg == 4'h8 && !ee_rd_reg) begin
					if (eshift_reg == {`CFG_EE_ADDR, `CFG_RW_READ}) begin
						ee_oe_reg <= 1'b1;
						ee_rd_reg <= 1'b1;
						eptr_reg  <= 8'h00;
						ebit_reg  <= 4'h9;
					end else begin
						ee_on_reg <= 1'b0;
					end
				end else if (ebit_reg == 4'h9) begin
					ee_oe_reg  <= ~ee_byte[7];
					eshift_reg <= {ee_byte[6:0], 1'b0};
					eptr_reg   <= eptr_reg + 8'h01;
					ebit_reg   <= 4'h0;
				end else if (ee_rd_reg) begin
					ee_oe_reg  <= (ebit_reg == 4'h8) ? 1'b0 : ~eshift_reg[7];
					eshift_reg <= {eshift_reg[6:0], 1'b0};
				end
			end
		end
	end

	// Controller: a read is a pointer write, a stop, then a one-byte read.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mb_reg     <= BUS_IDLE;
			ph_reg     <= 1'b0;
			bit_reg    <= 4'h0;
			shift_reg  <= 8'h00;
			idx_reg    <= 2'h0;
			last_reg   <= 2'h0;
			rd_reg     <= 1'b0;
			second_reg <= 1'b0;
			dev_reg    <= 7'h00;
			scl_oe_reg <= 1'b0;
			m_oe_reg   <= 1'b0;
			ready_reg  <= 1'b1;
			valid_reg  <= 1'b0;
			data_reg   <= 8'h00;
			nack_reg   <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				bytes[i] <= 8'h00;
			end
		end else if (ce) begin
			valid_reg <= 1'b0;
			if (mb_reg == BUS_IDLE) begin
				if (cmd_valid && ready_reg) begin
					bytes[0]   <= {cmd_dev, `CFG_RW_WRITE};
					bytes[1]   <= cmd_reg;
					bytes[2]   <= cmd_wdata;
					last_reg   <= cmd_rd ? 2'h1 : 2'h2;
					rd_reg     <= cmd_rd;
					dev_reg    <= cmd_dev;
					second_reg <= 1'b0;
					nack_reg   <= 1'b0;
					ready_reg  <= 1'b0;
					ph_reg     <= 1'b0;
					mb_reg     <= BUS_MSTART;
				end
			end else if (tick && mb_reg == BUS_MSTART) begin
				if (!ph_reg) begin
					m_oe_reg <= 1'b1;
					ph_reg   <= 1'b1;
				end else begin
					scl_oe_reg <= 1'b1;
					ph_reg     <= 1'b0;
					shift_reg  <= bytes[0];
					m_oe_reg   <= ~bytes[0][7];
					bit_reg    <= 4'h0;
					idx_reg    <= 2'h0;
					mb_reg     <= BUS_MTX;
				end
			end else if (tick && !ph_reg) begin
				scl_oe_reg <= 1'b0;
				ph_reg     <= 1'b1;
			end else if (tick) begin
				ph_reg <= 1'b0;
				if (mb_reg == BUS_MSTOP) begin
					m_oe_reg <= 1'b0;
					if (rd_reg && !second_reg && !nack_reg) begin
						second_reg <= 1'b1;
						bytes[0]   <= {dev_reg, `CFG_RW_READ};
						last_reg   <= 2'h0;
						mb_reg     <= BUS_MSTART;
					end else begin
						mb_reg    <= BUS_IDLE;
						ready_reg <= 1'b1;
						valid_reg <= 1'b1;
					end
				end else if (mb_reg == BUS_MTX) begin
					scl_oe_reg <= 1'b1;
					if (bit_reg == 4'h8) begin
						bit_reg <= 4'h0;
						if (sda_s || idx_reg == last_reg) begin
							nack_reg <= sda_s;
							m_oe_reg <= ~(second_reg && !sda_s);
							mb_reg   <= (second_reg && !sda_s) ? BUS_MRX : BUS_MSTOP;
						end else begin
							idx_reg   <= nxt;
							shift_reg <= bytes[nxt];
							m_oe_reg  <= ~bytes[nxt][7];
						end
					end else begin
						bit_reg   <= bit_reg + 4'h1;
						shift_reg <= {shift_reg[6:0], 1'b0};
						m_oe_reg  <= (bit_reg == 4'h7) ? 1'b0 : ~shift_reg[6];
					end
				end else begin
					scl_oe_reg <= 1'b1;
					if (bit_reg == 4'h8) begin
						m_oe_reg <= 1'b1;
						mb_reg   <= BUS_MSTOP;
					end else begin
						bit_reg   <= bit_reg + 4'h1;
						shift_reg <= {shift_reg[6:0], sda_s};
						if (bit_reg == 4'h7) begin
							data_reg <= {shift_reg[6:0], sda_s};
						end
					end
				end
			end
		end
	end
endmodule : cfg_host

// ==== cfg_link_sva.sv ====
// Checker of the loader link: bus ownership, load-done and lock-pin behaviour.
`timescale 1ns/1ps
module cfg_link_sva (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       sbclk_dev_oe,
	input wire logic       sda_dev_oe,
	input wire logic       done_dev_o,
	input wire logic       done_dev_oe,
	input wire logic       lock_dev_oe,
	input wire logic       lreq_n,
	input wire logic       config_mode_select_pin
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_load_end;
		$rose(done_dev_oe);
	endsequence
	sequence s_power_up;
		$rose(rst_n);
	endsequence
	chk_bus_needs_req: assert property (sbclk_dev_oe |-> !lreq_n)
		else $error("device clocks the bus without a load request");
	chk_done_needs_req: assert property (s_load_end |-> !lreq_n)
		else $error("load finished without a load request");
	chk_load_releases: assert property (s_load_end |-> !sbclk_dev_oe && !sda_dev_oe)
		else $error("bus still held when load-done is given");
	chk_done_sticky: assert property (done_dev_oe |=> done_dev_oe)
		else $error("load-done released before reset");
	chk_done_low: assert property (done_dev_oe |-> !done_dev_o)
		else $error("load-done not driven low");
	chk_master_ends: assert property (done_dev_oe |-> !sbclk_dev_oe)
		else $error("device masters the bus after its load");
	chk_slave_no_master: assert property (config_mode_select_pin |-> !sbclk_dev_oe)
		else $error("slave-mode device clocks the bus");
	chk_slave_no_done: assert property (config_mode_select_pin |-> !done_dev_oe)
		else $error("slave-mode device drives load-done");
	chk_lock_sticky: assert property (lock_dev_oe |=> lock_dev_oe)
		else $error("lock outputs dropped after the address latch");
	chk_latch_window: assert property (s_power_up |-> !lock_dev_oe ##[1:12] lock_dev_oe)
		else $error("strap latch did not happen in time");
endmodule : cfg_link_sva

// ==== tb.sv ====
// Self-checking bench of the loader and its host wired back to back.
`timescale 1ns/1ps
`include "cfg_defs.svh"
module tb;
	import cfg_pkg::*;
	logic       clk = 0, rst_n = 0, mode_high = 0, req_low = 1;
	logic       cmd_valid = 0, cmd_rd = 0, ce = 1;
	logic [3:0] strap_val = 0, lock = 0;
	logic [6:0] cmd_dev = 0, bus_addr, a;
	logic [7:0] cmd_reg = 0, cmd_wdata = 0, rd_idx = 0, rd_data, rsp_data, rg, wd;
	logic       slave_mode, load_done, cmd_ready, rsp_valid, rsp_nack, chain_done;
	cfg_state_e state;
	int         fail_count = 0, n_compared = 0, cyc = 0, n;
	always #12.5 clk = ~clk;
	cfg_link_if lk ();
	// A short bus half period keeps the run small; the synchronisers need at least 4.
	cfg_dev #(.REG_CNT(16), .SCL_HALF(4)) cfg_dev_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
		.link(lk.dev), .lock(lock), .rd_idx(rd_idx), .rd_data(rd_data), .bus_addr(bus_addr),
		.slave_mode(slave_mode), .load_done(load_done), .state(state));
	cfg_host #(.SCL_HALF(4)) cfg_host_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .link(lk.host),
		.mode_high(mode_high), .strap_val(strap_val), .req_low(req_low), .cmd_valid(cmd_valid),
		.cmd_rd(cmd_rd), .cmd_dev(cmd_dev), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_nack(rsp_nack), .chain_done(chain_done));
	cfg_link_sva cfg_link_sva_inst (.clk(clk), .rst_n(rst_n), .sbclk_dev_oe(lk.sbclk_dev_oe),
		.sda_dev_oe(lk.sda_dev_oe), .done_dev_o(lk.done_dev_o), .done_dev_oe(lk.done_dev_oe),
		.lock_dev_oe(lk.lock_dev_oe), .lreq_n(lk.lreq_n),
		.config_mode_select_pin(lk.config_mode_select_pin));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask : tick
	task automatic power_up(input logic m, input logic r, input logic [3:0] s);
		mode_high = m;
		req_low = r;
		strap_val = s;
		rst_n = 0;
		tick(3);
		rst_n = 1;
		tick(12);
	endtask : power_up
	task automatic xfer(input logic rd, input logic [6:0] dev, input logic [7:0] r, d);
		cmd_rd = rd;
		cmd_dev = dev;
		cmd_reg = r;
		cmd_wdata = d;
		cmd_valid = 1;
		tick(1);
		cmd_valid = 0;
		for (n = 0; n < 2000 && rsp_valid !== 1'b1; n++) tick(1);
		check("rsp_valid", rsp_valid, 1);
	endtask : xfer
	function automatic logic [6:0] exp_addr(input logic m, r, input logic [3:0] s);
		return (m && !r) ? 7'h18 : 7'h18 + {3'h0, s};
	endfunction : exp_addr
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			close_out();
		end
	end
	initial begin
		void'($urandom(53751));
		for (int i = 0; i < 16; i++) begin
			power_up(1, 1, i[3:0]);
			check("bus_addr", bus_addr, exp_addr(1, 1, i[3:0]));
			check("state", state, CFG_ST_SLAVE);
			check("slave_mode", slave_mode, 1);
			lock = 4'($urandom);
			tick(3);
			check("strap", lk.strap, lock);
			check("done_n", lk.done_n, 1);
		end
		$display("test slave_straps done");
		power_up(1, 1, 4'($urandom));
		a = exp_addr(1, 1, strap_val);
		for (int i = 0; i < 4; i++) begin
			rg = (i == 0) ? 8'h0f : 8'($urandom % 16);
			wd = 8'($urandom);
			xfer(0, a, rg, wd);
			check("wr_nack", rsp_nack, 0);
			xfer(1, a, rg, 8'h00);
			check("rd_byte", rsp_data, wd);
			rd_idx = rg;
			tick(2);
			check("reg", rd_data, wd);
		end
		xfer(0, a ^ 7'h01, 8'h00, 8'h5a);
		check("foreign_nack", rsp_nack, 1);
		check("cmd_ready", cmd_ready, 1);
		$display("test slave_access done");
		power_up(1, 0, 4'h9);
		check("fixed_addr", bus_addr, exp_addr(1, 0, 4'h9));
		xfer(0, 7'h18, 8'h01, 8'h3c);
		check("fixed_nack", rsp_nack, 0);
		$display("test fixed_addr done");
		// A load cut short by reset must restart cleanly after the next power-up.
		power_up(0, 1, 4'h3);
		tick(60);
		power_up(0, 0, 4'h6);
		check("wait", state, CFG_ST_WAIT);
		check("slave_mode", slave_mode, 0);
		tick(100);
		check("idle_clk", lk.serial_bus_clock_pin, 1);
		check("held_done", lk.done_n, 1);
		req_low = 1;
		// Freezing both ends together mid-load must leave the transfer intact.
		tick(30);
		ce = 0;
		tick(40);
		check("frozen_state", state, CFG_ST_LOAD);
		check("frozen_done", lk.done_n, 1);
		ce = 1;
		for (n = 0; n < 5000 && chain_done !== 1'b1; n++) tick(1);
		check("chain_done", chain_done, 1);
		check("done_n", lk.done_n, 0);
		check("load_done", load_done, 1);
		check("state", state, CFG_ST_SLAVE);
		check("addr", bus_addr, exp_addr(0, 0, 4'h6));
		for (int k = 0; k < 16; k++) begin
			rd_idx = 8'(k);
			tick(2);
			check("ee_byte", rd_data, `CFG_EE_SEED ^ 8'(k));
		end
		xfer(1, bus_addr, 8'h05, 8'h00);
		check("after_load", rsp_data, `CFG_EE_SEED ^ 8'h05);
		$display("test master_load done");
		close_out();
	end
endmodule : tb
